// ---- rtl/fault_retry_pkg.sv ----
// package of constants, register map and types for the fault retry controller
package fault_retry_pkg;

   // apb register byte offsets
   localparam logic [7:0] ADDR_TORQUE    = 8'h00; // torque cap, percent
   localparam logic [7:0] ADDR_NOLOAD    = 8'h04; // no-load current, percent
   localparam logic [7:0] ADDR_SLIPFILT  = 8'h08; // slip filter time, 0.1 s
   localparam logic [7:0] ADDR_RETRY     = 8'h0c; // retry limit
   localparam logic [7:0] ADDR_RIDE      = 8'h10; // ride-through time, 0.1 s
   localparam logic [7:0] ADDR_SEARCHLVL = 8'h14; // search current level
   localparam logic [7:0] ADDR_SEARCHDEC = 8'h18; // search decel time, 0.1 s
   localparam logic [7:0] ADDR_BLOCKTIME = 8'h1c; // min output block, 0.1 s
   localparam logic [7:0] ADDR_CONTROL   = 8'h20; // mode and option bits
   localparam logic [7:0] ADDR_STATUS    = 8'h24; // read-only state

   // control register field positions
   localparam int CTL_SENSORLESS = 0;   // sensorless mode select
   localparam int CTL_PL_CONT    = 1;   // power-loss continuation option
   localparam int CTL_FRESET     = 2;   // fault reset, self clearing

   // reset values of the settings
   localparam logic [7:0] RST_TORQUE    = 8'h96; // 150 %
   localparam logic [7:0] RST_NOLOAD    = 8'h1e; // 30 %
   localparam logic [7:0] RST_SLIP_GP   = 8'h14; // 2.0 s
   localparam logic [7:0] RST_SLIP_SL   = 8'h02; // 0.2 s
   localparam logic [7:0] RST_RETRY     = 8'h00; // no retries
   localparam logic [7:0] RST_RIDE      = 8'h14; // 2.0 s
   localparam logic [7:0] RST_SEARCHLVL = 8'h96; // 150 %
   localparam logic [7:0] RST_SEARCHDEC = 8'h14; // 2.0 s
   localparam logic [7:0] RST_BLOCKTIME = 8'h0a; // 1.0 s
   localparam logic [7:0] RST_CONTROL   = 8'h02; // continuation on

   // limits of the settings
   localparam logic [7:0] MAX_TORQUE    = 8'hc8; // 200 %
   localparam logic [7:0] MAX_NOLOAD    = 8'h63; // 99 %
   localparam logic [7:0] MAX_RETRY     = 8'h0a; // 10 attempts
   localparam logic [7:0] MAX_RIDE      = 8'h14; // 2.0 s
   localparam logic [7:0] MIN_BLOCK     = 8'h05; // 0.5 s
   localparam logic [7:0] MAX_BLOCK     = 8'h32; // 5.0 s

   // timing: clock rate and tick length
   localparam int CLK_HZ        = 50_000_000;
   localparam int TICK_MS       = 100;
   localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
   localparam int FAULTFREE_MIN = 10;
   localparam int FAULTFREE_TICKS = FAULTFREE_MIN * 60 * 1000 / TICK_MS;

   // trip inputs, one bit per cause
   typedef struct packed {
      logic overcurrent_trip;
      logic overvoltage_trip;
      logic motor_overload_trip;
      logic drive_overload_trip;
      logic overtorque_trip;
      logic overheat_trip;
      logic ground_fault_trip;
      logic undervoltage_trip;
   } trip_t;

   // sequencer states
   typedef enum logic [4:0] {
      ST_RUN    = 5'b00001,
      ST_BLOCK  = 5'b00010,
      ST_SEARCH = 5'b00100,
      ST_LOCK   = 5'b01000,
      ST_STOP   = 5'b10000
   } seq_t;

endpackage

// ---- rtl/fault_retry_speed_search_ctrl.sv ----
// fault retry, slip compensation, torque cap and speed search controller
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
module fault_retry_speed_search_ctrl
   import fault_retry_pkg::*;
#(
   parameter int FAULTFREE_LEN = FAULTFREE_TICKS // shorten for simulation
) (
   // clock and reset
   input  wire logic        MCLK,
   input  wire logic        RESET,
   // apb slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // drive state from same clock domain
   input  wire trip_t       TRIPS,
   input  wire logic        STOPPING,
   input  wire logic        POWER_LOSS,
   input  wire logic        REGEN,
   input  wire logic [15:0] FREQ_REF,
   input  wire logic [15:0] MIN_FREQ,
   input  wire logic [15:0] OUT_FREQ,
   input  wire logic [15:0] SLIP_RATED,
   input  wire logic [7:0]  OUT_CURRENT,
   // pin input
   input  wire logic        FAULT_RESET_PIN,
   // outputs to power stage and panel
   output logic             OUTPUT_BLOCK,
   output logic             SEARCH_ACTIVE,
   output logic [15:0]      SEARCH_FREQ,
   output logic [15:0]      SLIP_CORR,
   output logic [7:0]       TORQUE_LIMIT,
   output logic [7:0]       FAULT_CODE,
   output logic             FAULT_CONTACT,
   output logic [3:0]       RETRY_COUNT
);

   // settings registers
   logic [7:0]  torque_cap_setting_reg;
   logic [7:0]  no_load_current_setting_reg;
   logic [7:0]  slip_filter_time_reg;
   logic [7:0]  retry_limit_reg;
   logic [7:0]  ride_through_time_reg;
   logic [7:0]  search_current_level_reg;
   logic [7:0]  search_decel_time_reg;
   logic [7:0]  min_output_block_time_reg;
   logic [7:0]  control_reg;
   // sequencer state
   seq_t        state_reg;
   logic [3:0]  retry_reg;       // retry counter, saturating
   logic [7:0]  block_cnt_reg;   // block ticks elapsed
   logic [7:0]  down_cnt_reg;    // outage ticks elapsed
   logic [19:0] quiet_cnt_reg;   // fault-free ticks
   logic [22:0] tick_cnt_reg;    // 0.1 s divider
   logic        tick_reg;        // 0.1 s enable pulse
   logic [7:0]  code_reg;
   logic [15:0] hold_freq_reg;
   logic [31:0] filt_reg;        // filter state, 16.16
   logic [2:0]  rst_sync_reg;    // pin synchroniser
   logic        freset_reg;      // software fault reset pulse

   // apb decode
   wire         wr_en  = PSEL & PENABLE & PWRITE;
   wire         rd_en  = PSEL & ~PWRITE;
   wire [7:0]   wbyte  = PWDATA[7:0];
   wire         mapped = (PADDR <= ADDR_STATUS) && (PADDR[1:0] == 2'b00);

   // clamp a value into a range
   function automatic logic [7:0] clamp(input logic [7:0] v,
                                        input logic [7:0] lo,
                                        input logic [7:0] hi);
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   // trip derivations
   wire trip_any  = |TRIPS;
   wire pin_reset = rst_sync_reg[1] & rst_sync_reg[2];
   wire fault_rst = pin_reset | freset_reg;
   wire uv_block  = TRIPS.undervoltage_trip & ~control_reg[CTL_PL_CONT];
   wire ext_stop  = STOPPING &
                    (TRIPS.overcurrent_trip | TRIPS.overvoltage_trip);
   wire limit_hit = ({4'h0, retry_reg} >= retry_limit_reg);
   wire no_retry  = uv_block | ext_stop | limit_hit;
   wire [3:0] retry_inc = (retry_reg == 4'hf) ? retry_reg
                                               : retry_reg + 4'h1;
   wire search_on = (search_decel_time_reg != 8'h00);
   wire block_done = tick_reg && (block_cnt_reg + 8'h01 >=
                                  min_output_block_time_reg);
   wire outage_long = (down_cnt_reg >= min_output_block_time_reg);

   // first-byte encoding of the active trip
   wire [7:0] trip_code = {TRIPS};

   // slip correction target
   wire [15:0] noload_lvl = {8'h00, no_load_current_setting_reg};
   wire        slip_ok = ({8'h00, OUT_CURRENT} > noload_lvl) &&
                         (FREQ_REF > MIN_FREQ) && !REGEN;
   wire [7:0]  excess  = OUT_CURRENT - no_load_current_setting_reg;
   wire [7:0]  span    = 8'd100 - no_load_current_setting_reg;
   wire [23:0] prod    = SLIP_RATED * excess;
   wire [15:0] target  = slip_ok ? prod[23:8] + {8'h00, span[7:0] & 8'h00}
                                 : 16'h0000;
   wire [31:0] filt_err = {target, 16'h0000} - filt_reg;
   wire [7:0]  tau      = (slip_filter_time_reg == 8'h00) ? 8'h01
                                                          : slip_filter_time_reg;

   // apb register writes
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         torque_cap_setting_reg      <= RST_TORQUE;
         no_load_current_setting_reg <= RST_NOLOAD;
         slip_filter_time_reg        <= RST_SLIP_GP;
         retry_limit_reg             <= RST_RETRY;
         ride_through_time_reg       <= RST_RIDE;
         search_current_level_reg    <= RST_SEARCHLVL;
         search_decel_time_reg       <= RST_SEARCHDEC;
         min_output_block_time_reg   <= RST_BLOCKTIME;
         control_reg                 <= RST_CONTROL;
         freset_reg                  <= 1'b0;
      end else begin
         freset_reg <= 1'b0;
         if (wr_en) begin
            unique case (PADDR)
               ADDR_TORQUE:    torque_cap_setting_reg <=
                                  clamp(wbyte, 8'h00, MAX_TORQUE);
               ADDR_NOLOAD:    no_load_current_setting_reg <=
                                  clamp(wbyte, 8'h00, MAX_NOLOAD);
               ADDR_SLIPFILT:  slip_filter_time_reg <= wbyte;
               ADDR_RETRY:     retry_limit_reg <=
                                  clamp(wbyte, 8'h00, MAX_RETRY);
               ADDR_RIDE:      ride_through_time_reg <=
                                  clamp(wbyte, 8'h00, MAX_RIDE);
               ADDR_SEARCHLVL: search_current_level_reg <=
                                  clamp(wbyte, 8'h00, MAX_TORQUE);
               ADDR_SEARCHDEC: search_decel_time_reg <= wbyte;
               ADDR_BLOCKTIME: min_output_block_time_reg <=
                                  clamp(wbyte, MIN_BLOCK, MAX_BLOCK);
               ADDR_CONTROL: begin
                  // mode change loads that mode's default filter time
                  if (wbyte[CTL_SENSORLESS] != control_reg[CTL_SENSORLESS])
                     slip_filter_time_reg <= wbyte[CTL_SENSORLESS] ?
                                             RST_SLIP_SL : RST_SLIP_GP;
                  control_reg <= {6'h00, wbyte[1:0]};
                  freset_reg  <= wbyte[CTL_FRESET];
               end
               default: ;
            endcase
         end
      end
   end

   // apb read and answer; no wait states, error on unmapped address
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         PRDATA  <= 32'h0000_0000;
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= PSEL & ~PENABLE;
         PSLVERR <= PSEL & ~PENABLE & ~mapped;
         if (rd_en & ~PENABLE) begin
            unique case (PADDR)
               ADDR_TORQUE:    PRDATA <= {24'h0, torque_cap_setting_reg};
               ADDR_NOLOAD:    PRDATA <= {24'h0, no_load_current_setting_reg};
               ADDR_SLIPFILT:  PRDATA <= {24'h0, slip_filter_time_reg};
               ADDR_RETRY:     PRDATA <= {24'h0, retry_limit_reg};
               ADDR_RIDE:      PRDATA <= {24'h0, ride_through_time_reg};
               ADDR_SEARCHLVL: PRDATA <= {24'h0, search_current_level_reg};
               ADDR_SEARCHDEC: PRDATA <= {24'h0, search_decel_time_reg};
               ADDR_BLOCKTIME: PRDATA <= {24'h0, min_output_block_time_reg};
               ADDR_CONTROL:   PRDATA <= {24'h0, control_reg};
               ADDR_STATUS:    PRDATA <= {11'h0, state_reg, code_reg,
                                          4'h0, retry_reg};
               default:        PRDATA <= 32'h0000_0000;
            endcase
         end
      end
   end

   // fault reset pin synchroniser
   always_ff @(posedge MCLK) begin
      if (RESET)
         rst_sync_reg <= 3'b000;
      else
         rst_sync_reg <= {rst_sync_reg[1:0], FAULT_RESET_PIN};
   end

   // 0.1 s tick divider
   always_ff @(posedge MCLK) begin
      if (RESET || tick_cnt_reg == 23'(TICK_CYCLES - 1)) begin
         tick_cnt_reg <= 23'h0;
         tick_reg     <= ~RESET;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 23'h1;
         tick_reg     <= 1'b0;
      end
   end

   // fault-free timer and retry counter
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         quiet_cnt_reg <= 20'h0;
         retry_reg     <= 4'h0;
      end else if (trip_any && state_reg == ST_RUN) begin
         quiet_cnt_reg <= 20'h0;
         retry_reg     <= retry_inc;
      end else if (fault_rst) begin
         retry_reg     <= 4'h0;
         quiet_cnt_reg <= 20'h0;
      end else if (tick_reg) begin
         if (quiet_cnt_reg + 20'h1 >= 20'(FAULTFREE_LEN)) begin
            retry_reg     <= 4'h0;
            quiet_cnt_reg <= 20'h0;
         end else begin
            quiet_cnt_reg <= quiet_cnt_reg + 20'h1;
         end
      end
   end

   // restart sequencer
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         state_reg     <= ST_RUN;
         block_cnt_reg <= 8'h0;
         down_cnt_reg  <= 8'h0;
         code_reg      <= 8'h0;
         hold_freq_reg <= 16'h0;
      end else begin
         unique case (state_reg)
            ST_RUN: begin
               block_cnt_reg <= 8'h0;
               if (trip_any) begin
                  code_reg      <= trip_code;
                  hold_freq_reg <= OUT_FREQ;
                  if (retry_limit_reg == 8'h00 || ext_stop || uv_block)
                     state_reg <= ST_STOP;
                  else if ({4'h0, retry_inc} > retry_limit_reg)
                     state_reg <= ST_LOCK;
                  else
                     state_reg <= ST_BLOCK;
               end else if (POWER_LOSS) begin
                  hold_freq_reg <= OUT_FREQ;
                  down_cnt_reg  <= 8'h0;
                  state_reg     <= ST_BLOCK;
               end
            end
            ST_BLOCK: begin
               if (tick_reg) begin
                  block_cnt_reg <= block_cnt_reg + 8'h01;
                  if (POWER_LOSS)
                     down_cnt_reg <= down_cnt_reg + 8'h01;
               end
               if (block_done && !POWER_LOSS) begin
                  code_reg <= 8'h00;
                  state_reg <= search_on ? ST_SEARCH : ST_RUN;
               end
            end
            ST_SEARCH: begin
               // stay while current at or above level, then resync
               if (OUT_CURRENT < search_current_level_reg)
                  state_reg <= ST_RUN;
               else if (tick_reg && hold_freq_reg != 16'h0)
                  hold_freq_reg <= hold_freq_reg -
                     (hold_freq_reg / {8'h0, search_decel_time_reg});
            end
            ST_LOCK, ST_STOP: begin
               if (fault_rst) begin
                  code_reg  <= 8'h00;
                  state_reg <= ST_RUN;
               end
            end
            default: state_reg <= ST_RUN;
         endcase
      end
   end

   // slip correction first-order filter, updated each tick
   always_ff @(posedge MCLK) begin
      if (RESET)
         filt_reg <= 32'h0;
      else if (tick_reg)
         filt_reg <= filt_reg + 32'($signed(filt_err) /
                                    $signed({24'h0, tau}));
   end

   // output registers
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         OUTPUT_BLOCK  <= 1'b0;
         SEARCH_ACTIVE <= 1'b0;
         SEARCH_FREQ   <= 16'h0;
         SLIP_CORR     <= 16'h0;
         TORQUE_LIMIT  <= RST_TORQUE;
         FAULT_CODE    <= 8'h0;
         FAULT_CONTACT <= 1'b0;
         RETRY_COUNT   <= 4'h0;
      end else begin
         OUTPUT_BLOCK  <= (state_reg != ST_RUN) &&
                          (state_reg != ST_SEARCH);
         SEARCH_ACTIVE <= (state_reg == ST_SEARCH);
         SEARCH_FREQ   <= hold_freq_reg;
         SLIP_CORR     <= filt_reg[31:16];
         TORQUE_LIMIT  <= control_reg[CTL_SENSORLESS] ?
                          torque_cap_setting_reg : MAX_TORQUE;
         FAULT_CODE    <= code_reg;
         FAULT_CONTACT <= (state_reg == ST_LOCK) ||
                          (state_reg == ST_STOP);
         RETRY_COUNT   <= retry_reg;
      end
   end

   // assertions
   property p_lock_contact;
      @(posedge MCLK) disable iff (RESET)
      (state_reg == ST_LOCK) |=> FAULT_CONTACT;
   endproperty
   a_lock_contact: assert property (p_lock_contact)
      else $error("fault contact missing in lockout");

   property p_zero_limit;
      @(posedge MCLK) disable iff (RESET)
      (state_reg == ST_RUN && trip_any && retry_limit_reg == 8'h00)
      |=> state_reg == ST_STOP;
   endproperty
   a_zero_limit: assert property (p_zero_limit)
      else $error("retry taken with zero limit");

   property p_trip_count;
      @(posedge MCLK) disable iff (RESET)
      (state_reg == ST_RUN && trip_any && retry_reg < 4'hf)
      |=> retry_reg == $past(retry_reg) + 4'h1;
   endproperty
   a_trip_count: assert property (p_trip_count)
      else $error("retry counter not incremented");

   property p_uv_hold;
      @(posedge MCLK) disable iff (RESET)
      (state_reg == ST_RUN && uv_block) |=> state_reg == ST_STOP;
   endproperty
   a_uv_hold: assert property (p_uv_hold)
      else $error("undervoltage retried with option off");

   property p_ext_stop;
      @(posedge MCLK) disable iff (RESET)
      (state_reg == ST_RUN && ext_stop) |=> state_reg == ST_STOP;
   endproperty
   a_ext_stop: assert property (p_ext_stop)
      else $error("external trip while stopping was retried");

   property p_reset_clear;
      @(posedge MCLK) disable iff (RESET)
      (fault_rst && !(trip_any && state_reg == ST_RUN)) |=> retry_reg == 0;
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("fault reset did not clear counter");

   property p_block_out;
      @(posedge MCLK) disable iff (RESET)
      (state_reg == ST_BLOCK) ##1 (state_reg == ST_BLOCK) |-> OUTPUT_BLOCK;
   endproperty
   a_block_out: assert property (p_block_out)
      else $error("output not blocked during block time");

   property p_no_slip_regen;
      @(posedge MCLK) disable iff (RESET)
      REGEN [*2] |-> target == 16'h0000;
   endproperty
   a_no_slip_regen: assert property (p_no_slip_regen)
      else $error("slip target nonzero while regenerating");

   property p_saturate;
      @(posedge MCLK) disable iff (RESET)
      (retry_reg == 4'hf) |=> retry_reg inside {4'hf, 4'h0};
   endproperty
   a_saturate: assert property (p_saturate)
      else $error("retry counter wrapped");

   c_retry: cover property (@(posedge MCLK) state_reg == ST_BLOCK
                            ##1 state_reg == ST_SEARCH);
   c_lock:  cover property (@(posedge MCLK) state_reg == ST_LOCK);
   c_stop:  cover property (@(posedge MCLK) state_reg == ST_STOP);
   c_slip:  cover property (@(posedge MCLK) slip_ok);

endmodule

// ---- testbench/power_stage_model.sv ----
// behavioural power output stage and motor seen by the controller
`timescale 1ns/100ps
module power_stage_model (
   // clock
   input  wire logic        clk,
   // commands from the controller
   input  wire logic        block,
   input  wire logic        search,
   input  wire logic [15:0] search_freq,
   // load the bench asks for, percent of rated current
   input  wire logic [7:0]  load,
   // measured feedback
   output logic      [15:0] freq,
   output logic      [7:0]  current
);
   // an idle stage draws no current; a blocked motor coasts down
   always @(posedge clk) begin
      if (block) begin
         current <= 8'h00;
         freq    <= (freq > 16'h0000) ? freq - 16'h0001 : 16'h0000;
      end else if (search) begin
         current <= load;
         freq    <= search_freq;
      end else begin
         current <= load;
      end
   end
   initial begin
      freq    = 16'h03e8;
      current = 8'h00;
   end
endmodule

// ---- testbench/tb.sv ----
// self-checking bench for the fault retry and speed search controller
`timescale 1ns/100ps
module tb;
   import fault_retry_pkg::*;
   logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, frp = 0;
   logic        stop = 0, ploss = 0, regen = 0, blk, srch, fc, rdy, err;
   logic [7:0]  pa = 8'h00, load = 8'h28, cur, tl, code;
   logic [31:0] pwd = 32'h0, prd, r;
   logic [15:0] fref = 16'h03e8, fmin = 16'h000a, slip = 16'h0050;
   logic [15:0] ofreq, sfreq, scorr;
   logic [3:0]  cnt;
   logic        se;             // pslverr taken with pready
   trip_t       trips = trip_t'(8'h00);
   int          n_errors = 0, num_checks = 0, k;
   logic [7:0]  dflt [9] = '{RST_TORQUE, RST_NOLOAD, RST_SLIP_GP, RST_RETRY,
      RST_RIDE, RST_SEARCHLVL, RST_SEARCHDEC, RST_BLOCKTIME, RST_CONTROL};
   // free running 50 MHz clock
   initial forever #10 clk = ~clk;
   fault_retry_speed_search_ctrl #(.FAULTFREE_LEN(6000)) dut (.MCLK(clk),
      .RESET(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
      .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err),
      .TRIPS(trips), .STOPPING(stop), .POWER_LOSS(ploss), .REGEN(regen),
      .FREQ_REF(fref), .MIN_FREQ(fmin), .OUT_FREQ(ofreq),
      .SLIP_RATED(slip), .OUT_CURRENT(cur), .FAULT_RESET_PIN(frp),
      .OUTPUT_BLOCK(blk), .SEARCH_ACTIVE(srch), .SEARCH_FREQ(sfreq),
      .SLIP_CORR(scorr), .TORQUE_LIMIT(tl), .FAULT_CODE(code),
      .FAULT_CONTACT(fc), .RETRY_COUNT(cnt));
   power_stage_model motor (.clk(clk), .block(blk), .search(srch),
      .search_freq(sfreq), .load(load), .freq(ofreq), .current(cur));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one comparison, counted
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one apb transfer: setup, then access until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= d;
      @(posedge clk);
      pen <= 1;
      do begin
         @(posedge clk);
         n++;
      end while (rdy !== 1'b1 && n < 40);
      if (n >= 40) chk("pready", 1, 0);
      r = prd;
      se = err;
      psel <= 0;
      pen <= 0;
      @(posedge clk);
   endtask
   // raise one trip, let the sequencer act, then compare its outputs
   task automatic trip(input logic [7:0] v, input logic [4:0] st, input logic c);
      trips <= trip_t'(v);
      cyc(6);
      chk("count", 1, cnt);
      chk("block", 1, blk);
      chk("code", v, code);
      chk("contact", c, fc);
      trips <= trip_t'(8'h00);
      apb(0, ADDR_STATUS, 0);
      chk("state", st, r[20:16]);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // watchdog
   initial begin
      #400000;
      n_errors++;
      tally_and_finish;
   end
   initial begin
      void'($urandom(32'h1dfcb1d5));
      cyc(12);
      rst <= 0;
      cyc(1);
      for (k = 0; k < 9; k++) begin
         apb(0, 8'(k * 4), 0);
         chk("reset value", {24'h0, dflt[k]}, r);
      end
      apb(1, 8'h28, 32'h5a); // unmapped place refuses
      chk("slverr", 1, se);
      apb(0, 8'h28, 0);
      chk("unmapped", 0, r);
      apb(1, ADDR_RETRY, 32'h0f);
      apb(0, ADDR_RETRY, 0);
      chk("retry clamp", MAX_RETRY, r);
      apb(1, ADDR_BLOCKTIME, 32'h01);
      apb(0, ADDR_BLOCKTIME, 0);
      chk("block clamp", MIN_BLOCK, r);
      apb(1, ADDR_CONTROL, 32'h03);
      apb(1, ADDR_TORQUE, 32'hff);
      apb(0, ADDR_TORQUE, 0);
      chk("torque clamp", MAX_TORQUE, r);
      k = $urandom_range(200);
      apb(1, ADDR_TORQUE, k);
      cyc(3);
      chk("torque cap", k, tl);
      regen <= 1;
      load <= 8'hc8;
      cyc(30);
      chk("regen slip", 0, scorr);
      regen <= 0;
      apb(1, ADDR_RETRY, 0);
      trip(8'h80, ST_STOP, 1);
      frp <= 1;
      cyc(8);
      frp <= 0;
      cyc(3);
      chk("pin clear", 0, cnt);
      apb(1, ADDR_RETRY, 32'h0a);
      stop <= 1;
      trip(8'h40, ST_STOP, 1);
      stop <= 0;
      apb(1, ADDR_CONTROL, 32'h07);
      cyc(3);
      chk("reg clear", 0, cnt);
      do k = $urandom_range(7); while (k == 3);
      trip(8'h01 << k, ST_BLOCK, 0);
      tally_and_finish;
   end
endmodule
